/* File: rbt_bus_partner.sv */
`default_nettype none
module rbt_bus_partner (
   input  wire logic [7:0] a_out,
   input  wire logic       a_oe,
   input  wire logic [7:0] b_out,
   input  wire logic       b_oe,
   input  wire logic [7:0] a_far,
   input  wire logic [7:0] b_far,
   output logic [7:0]      a_in,
   output logic [7:0]      b_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // far side backs off whenever the device drives, so the wire never carries two drivers
   assign a_in = a_oe ? a_out : a_far;
   assign b_in = b_oe ? b_out : b_far;
endmodule
`default_nettype wire

/* File: rbt_capture.sv */
`default_nettype none
module rbt_capture (
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic cap_clk,
   rbt_lane_if.cap   lane
);
   logic cap_prev;

   // prev tracks the pin through reset: a clock high at release is no edge,
   // yet a rise on the first edge after release is still caught
   always_ff @(posedge clk) begin
      cap_prev <= cap_clk;
   end

   // no gate or heading term here: capture is never blocked
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         lane.stored <= '0;
      end else if (cap_clk && !cap_prev) begin
         lane.stored <= lane.live;
      end
   end
endmodule
`default_nettype wire

/* File: rbt_lane_if.sv */
`default_nettype none
interface rbt_lane_if #(
   parameter int W = 8
);
   logic [W-1:0] live;
   logic [W-1:0] stored;

   modport cap (
      input  live,
      output stored
   );
   modport use_side (
      input  live,
      input  stored
   );
endinterface
`default_nettype wire

/* File: rbt_pkg.sv */
`default_nettype none
package rbt_pkg;
   typedef struct packed {
      logic b_side_source_select;
      logic a_side_source_select;
      logic port_heading;
      logic drive_gate_n;
   } rbt_ctrl_t;

   typedef enum logic {
      rbt_bus_idle,
      rbt_bus_answer
   } rbt_bus_state_t;
endpackage
`default_nettype wire

/* File: rbt_port_drive.sv */
`default_nettype none
module rbt_port_drive #(
   parameter int W = 8
) (
   input  wire logic         clk,
   input  wire logic         sys_rst,
   input  wire logic         drive_en,
   input  wire logic         use_stored,
   rbt_lane_if.use_side      opp,
   output logic [W-1:0]      dout,
   output logic              oe
);
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         oe <= 1'b0;
      end else begin
         oe <= drive_en;
      end
   end

   // data is muxed every cycle; only oe decides whether it reaches the wire
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         dout <= '0;
      end else if (use_stored) begin
         dout <= opp.stored;
      end else begin
         dout <= opp.live;
      end
   end
endmodule
`default_nettype wire

/* File: rbt_regs.svh */
// Operation
// - A rising a_to_b_capture_clock loads port A into the A-to-B register, and a rising b_to_a_capture_clock loads port B into the B-to-A register.
// - The output gate and the port heading never block a capture, so every rising capture clock stores the bus value.
// - With drive_gate_n high neither port is driven, both registers may still capture, and without capture edges both hold.
// - With drive_gate_n low, port_heading low drives port A and port_heading high drives port B.
// - When port A is driven it carries live port B data if a_side_source_select is low, else the B-to-A register.
// - When port B is driven it carries live port A data if b_side_source_select is low, else the A-to-B register.
// - At most one of the two ports is driven under any combination of controls.
// - While one port is driven, data at the other port may be captured into either register or both.
`ifndef RBT_REGS_SVH
`define RBT_REGS_SVH

`define RBT_DATA_W           8
`define RBT_ADDR_W           4
`define RBT_CTRL_OFFSET      4'h0
`define RBT_STATUS_OFFSET    4'h4
`define RBT_LIVE_OFFSET      4'h8
`define RBT_CTRL_RESET       4'h1
`define RBT_CTRL_GATE_BIT    0
`define RBT_CTRL_HEAD_BIT    1
`define RBT_CTRL_ASEL_BIT    2
`define RBT_CTRL_BSEL_BIT    3
`define RBT_STAT_AB_LSB      0
`define RBT_STAT_BA_LSB      8
`define RBT_STAT_AOE_BIT     16
`define RBT_STAT_BOE_BIT     17
`define RBT_LIVE_A_LSB       0
`define RBT_LIVE_B_LSB       8
`define RBT_READ_ZERO        32'h0000_0000

`endif

/* File: rbt_transceiver.sv */
`include "rbt_regs.svh"
`default_nettype none
module rbt_transceiver #(
   parameter int W = `RBT_DATA_W
) (
   input  wire logic                   clk,
   input  wire logic                   sys_rst,
   input  wire logic [`RBT_ADDR_W-1:0] avs_address,
   input  wire logic                   avs_read,
   input  wire logic                   avs_write,
   input  wire logic [31:0]            avs_writedata,
   input  wire logic [3:0]             avs_byteenable,
   output logic [31:0]                 avs_readdata,
   output logic                        avs_waitrequest,
   input  wire logic                   a_to_b_capture_clock,
   input  wire logic                   b_to_a_capture_clock,
   input  wire logic [W-1:0]           a_in,
   output logic [W-1:0]                a_out,
   output logic                        a_oe,
   input  wire logic [W-1:0]           b_in,
   output logic [W-1:0]                b_out,
   output logic                        b_oe
);
   rbt_pkg::rbt_ctrl_t      ctrl;
   rbt_pkg::rbt_bus_state_t bus_state;
   logic [31:0]             next_readdata;
   logic                    drive_a;
   logic                    drive_b;
   logic                    bus_req;
   logic                    bus_done;

   rbt_lane_if #(.W(W)) lane_a ();
   rbt_lane_if #(.W(W)) lane_b ();

   assign lane_a.live = a_in;
   assign lane_b.live = b_in;

   // lane_a.stored is the A-to-B register, lane_b.stored the B-to-A one
   rbt_capture u_cap_ab (
      .clk     (clk),
      .sys_rst (sys_rst),
      .cap_clk (a_to_b_capture_clock),
      .lane    (lane_a.cap)
   );

   rbt_capture u_cap_ba (
      .clk     (clk),
      .sys_rst (sys_rst),
      .cap_clk (b_to_a_capture_clock),
      .lane    (lane_b.cap)
   );

   // both enables come from one heading bit, so they can never both be set
   assign drive_a = !ctrl.drive_gate_n && !ctrl.port_heading;
   assign drive_b = !ctrl.drive_gate_n && ctrl.port_heading;

   rbt_port_drive #(.W(W)) u_drive_a (
      .clk        (clk),
      .sys_rst    (sys_rst),
      .drive_en   (drive_a),
      .use_stored (ctrl.a_side_source_select),
      .opp        (lane_b.use_side),
      .dout       (a_out),
      .oe         (a_oe)
   );

   rbt_port_drive #(.W(W)) u_drive_b (
      .clk        (clk),
      .sys_rst    (sys_rst),
      .drive_en   (drive_b),
      .use_stored (ctrl.b_side_source_select),
      .opp        (lane_a.use_side),
      .dout       (b_out),
      .oe         (b_oe)
   );

   // bus slave: one wait cycle, then waitrequest low for exactly one edge
   assign bus_req  = avs_read || avs_write;
   assign bus_done = bus_req && !avs_waitrequest;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         bus_state <= rbt_pkg::rbt_bus_idle;
      end else begin
         case (bus_state)
            rbt_pkg::rbt_bus_idle: begin
               if (bus_req) begin
                  bus_state <= rbt_pkg::rbt_bus_answer;
               end
            end
            rbt_pkg::rbt_bus_answer: begin
               bus_state <= rbt_pkg::rbt_bus_idle;
            end
            default: begin
               bus_state <= rbt_pkg::rbt_bus_idle;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= !(bus_state == rbt_pkg::rbt_bus_idle && bus_req);
      end
   end

   always_comb begin
      next_readdata = `RBT_READ_ZERO;
      if (avs_address == `RBT_CTRL_OFFSET) begin
         next_readdata[3:0] = ctrl;
      end else if (avs_address == `RBT_STATUS_OFFSET) begin
         next_readdata[`RBT_STAT_AB_LSB +: W] = lane_a.stored;
         next_readdata[`RBT_STAT_BA_LSB +: W] = lane_b.stored;
         next_readdata[`RBT_STAT_AOE_BIT]     = a_oe;
         next_readdata[`RBT_STAT_BOE_BIT]     = b_oe;
      end else if (avs_address == `RBT_LIVE_OFFSET) begin
         next_readdata[`RBT_LIVE_A_LSB +: W] = a_in;
         next_readdata[`RBT_LIVE_B_LSB +: W] = b_in;
      end
   end

   // data is set up with waitrequest low and held until the next read request
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         avs_readdata <= `RBT_READ_ZERO;
      end else if (bus_state == rbt_pkg::rbt_bus_idle && avs_read) begin
         avs_readdata <= next_readdata;
      end
   end

   // a write lands only on the edge that sees waitrequest low
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl <= rbt_pkg::rbt_ctrl_t'(`RBT_CTRL_RESET);
      end else if (bus_done && avs_write && avs_byteenable[0] && avs_address == `RBT_CTRL_OFFSET) begin
         ctrl.drive_gate_n         <= avs_writedata[`RBT_CTRL_GATE_BIT];
         ctrl.port_heading         <= avs_writedata[`RBT_CTRL_HEAD_BIT];
         ctrl.a_side_source_select <= avs_writedata[`RBT_CTRL_ASEL_BIT];
         ctrl.b_side_source_select <= avs_writedata[`RBT_CTRL_BSEL_BIT];
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   sequence s_ab_rise;
      a_to_b_capture_clock && !$past(a_to_b_capture_clock);
   endsequence

   sequence s_ba_rise;
      b_to_a_capture_clock && !$past(b_to_a_capture_clock);
   endsequence

   sequence s_drive_a;
      !ctrl.drive_gate_n && !ctrl.port_heading;
   endsequence

   sequence s_drive_b;
      !ctrl.drive_gate_n && ctrl.port_heading;
   endsequence

   a_capture_a_reg: assert property (s_ab_rise |=> lane_a.stored == $past(a_in))
      else $error("a-to-b register missed a capture");

   a_capture_b_reg: assert property (s_ba_rise |=> lane_b.stored == $past(b_in))
      else $error("b-to-a register missed a capture");

   a_capture_while_driving: assert property ((s_ab_rise and s_drive_b) |=> lane_a.stored == $past(a_in))
      else $error("capture blocked while port b driven");

   a_isolation_no_drive: assert property (ctrl.drive_gate_n |=> !a_oe && !b_oe)
      else $error("a port driven while gate is high");

   a_hold_without_edge: assert property (
      !(a_to_b_capture_clock && !$past(a_to_b_capture_clock))
      && !(b_to_a_capture_clock && !$past(b_to_a_capture_clock))
      |=> $stable(lane_a.stored) && $stable(lane_b.stored))
      else $error("register changed without a capture edge");

   a_heading_selects_a: assert property (s_drive_a |=> a_oe && !b_oe)
      else $error("port a not driven for heading low");

   a_heading_selects_b: assert property (s_drive_b |=> b_oe && !a_oe)
      else $error("port b not driven for heading high");

   a_a_live_data: assert property ((s_drive_a ##0 !ctrl.a_side_source_select) |=> a_out == $past(b_in))
      else $error("port a does not carry live b data");

   a_a_stored_data: assert property ((s_drive_a ##0 ctrl.a_side_source_select) |=> a_out == $past(lane_b.stored))
      else $error("port a does not carry stored b data");

   a_b_live_data: assert property ((s_drive_b ##0 !ctrl.b_side_source_select) |=> b_out == $past(a_in))
      else $error("port b does not carry live a data");

   a_b_stored_data: assert property ((s_drive_b ##0 ctrl.b_side_source_select) |=> b_out == $past(lane_a.stored))
      else $error("port b does not carry stored a data");

   a_single_driver: assert property (!(a_oe && b_oe))
      else $error("both ports driven at once");

   a_capture_both_regs: assert property ((s_ab_rise and s_ba_rise and s_drive_a)
      |=> lane_a.stored == $past(a_in) && lane_b.stored == $past(b_in))
      else $error("dual capture failed while driving port a");

   a_lanes_alike: assert property ((s_drive_a ##0 !ctrl.a_side_source_select) |=> a_out[W-1:0] == $past(b_in[W-1:0]))
      else $error("a lane of port a differs from its source");

   a_bus_answer_time: assert property ((bus_req && bus_state == rbt_pkg::rbt_bus_idle) |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus answer not one cycle after request");

   a_bus_ctrl_write: assert property ((bus_done && avs_write && avs_byteenable[0] && avs_address == `RBT_CTRL_OFFSET)
      |=> ctrl == $past(avs_writedata[3:0]))
      else $error("control write did not land");

   sequence s_read_take;
      avs_read && bus_state == rbt_pkg::rbt_bus_idle;
   endsequence

   // read data must stand until the next taken read, the master may sample late
   a_readdata_holds: assert property (!(avs_read && bus_state == rbt_pkg::rbt_bus_idle) |=> $stable(avs_readdata))
      else $error("read data changed without a read");

   a_unmapped_zero: assert property ((s_read_take ##0 (avs_address != `RBT_CTRL_OFFSET
      && avs_address != `RBT_STATUS_OFFSET && avs_address != `RBT_LIVE_OFFSET)) |=> avs_readdata == `RBT_READ_ZERO)
      else $error("unmapped read returned data");

   a_wait_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");

   a_ctrl_stable: assert property (!(bus_done && avs_write && avs_byteenable[0] && avs_address == `RBT_CTRL_OFFSET)
      |=> $stable(ctrl))
      else $error("control changed without a control write");
endmodule
`default_nettype wire

/* File: rbt_transceiver_tb.sv */
`default_nettype none
module rbt_transceiver_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk            = 1'b0;
   logic        sys_rst        = 1'b1;
   logic [3:0]  avs_address    = 4'h0;
   logic        avs_read       = 1'b0;
   logic        avs_write      = 1'b0;
   logic [31:0] avs_writedata  = 32'h0000_0000;
   logic [3:0]  avs_byteenable = 4'hF;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        cap_ab         = 1'b0;
   logic        cap_ba         = 1'b0;
   logic [7:0]  a_far          = 8'h00;
   logic [7:0]  b_far          = 8'h00;
   logic [7:0]  a_in;
   logic [7:0]  a_out;
   logic [7:0]  b_in;
   logic [7:0]  b_out;
   logic        a_oe;
   logic        b_oe;
   logic [31:0] rd;
   logic [3:0]  cv;
   logic [7:0]  exp_a;
   logic [7:0]  exp_b;
   int          mismatches      = 0;
   int          samples_checked = 0;
   int          cycles          = 0;

   rbt_transceiver i_rbt_transceiver (
      .clk                  (clk),
      .sys_rst              (sys_rst),
      .avs_address          (avs_address),
      .avs_read             (avs_read),
      .avs_write            (avs_write),
      .avs_writedata        (avs_writedata),
      .avs_byteenable       (avs_byteenable),
      .avs_readdata         (avs_readdata),
      .avs_waitrequest      (avs_waitrequest),
      .a_to_b_capture_clock (cap_ab),
      .b_to_a_capture_clock (cap_ba),
      .a_in                 (a_in),
      .a_out                (a_out),
      .a_oe                 (a_oe),
      .b_in                 (b_in),
      .b_out                (b_out),
      .b_oe                 (b_oe)
   );

   rbt_bus_partner i_rbt_bus_partner (
      .a_out (a_out),
      .a_oe  (a_oe),
      .b_out (b_out),
      .b_oe  (b_oe),
      .a_far (a_far),
      .b_far (b_far),
      .a_in  (a_in),
      .b_in  (b_in)
   );

   always #5 clk = ~clk;

   task automatic results();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         results();
      end
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      samples_checked++;
      if (got !== ex) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, ex, got);
      end
   endtask

   // one full access; the extra edge at the end keeps back-to-back calls from
   // assigning the strobe twice in one time step
   task automatic bus(input logic wr, input logic [3:0] ad, input logic [31:0] wd, input logic [3:0] be);
      avs_address    <= ad;
      avs_writedata  <= wd;
      avs_byteenable <= be;
      avs_read       <= !wr;
      avs_write      <= wr;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) @(posedge clk);
      rd = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
   endtask

   // rise held two edges, then low two edges so the next rise is seen
   task automatic cap(input logic ab, input logic ba);
      cap_ab <= ab;
      cap_ba <= ba;
      tick(2);
      cap_ab <= 1'b0;
      cap_ba <= 1'b0;
      tick(2);
   endtask

   initial begin
      tick(2);
      sys_rst <= 1'b0;
      tick(1);
      bus(1'b0, 4'h0, 32'h0000_0000, 4'hF);
      chk("ctrl reset", 32'h0000_0001, rd);
      bus(1'b0, 4'h4, 32'h0000_0000, 4'hF);
      chk("status reset", 32'h0000_0000, rd);
      chk("oe reset", 32'h0000_0000, {30'h0000_0000, a_oe, b_oe});
      $display("test reset done");

      a_far <= 8'h5A;
      b_far <= 8'hC3;
      tick(1);
      cap(1'b1, 1'b1);
      bus(1'b0, 4'h4, 32'h0000_0000, 4'hF);
      chk("status both", 32'h0000_C35A, rd);
      a_far <= 8'h00;
      b_far <= 8'hFF;
      tick(4);
      bus(1'b0, 4'h4, 32'h0000_0000, 4'hF);
      chk("status hold", 32'h0000_C35A, rd);
      bus(1'b0, 4'h8, 32'h0000_0000, 4'hF);
      chk("live", 32'h0000_FF00, rd);
      bus(1'b0, 4'hC, 32'h0000_0000, 4'hF);
      chk("unmapped", 32'h0000_0000, rd);
      bus(1'b1, 4'h4, 32'hFFFF_FFFF, 4'hF);
      bus(1'b0, 4'h4, 32'h0000_0000, 4'hF);
      chk("status ro", 32'h0000_C35A, rd);
      bus(1'b1, 4'h0, 32'h0000_0000, 4'h0);
      bus(1'b0, 4'h0, 32'h0000_0000, 4'hF);
      chk("ctrl be0", 32'h0000_0001, rd);
      $display("test isolation done");

      bus(1'b1, 4'h0, 32'h0000_0002, 4'hF);
      a_far <= 8'h96;
      tick(1);
      cap(1'b1, 1'b0);
      bus(1'b1, 4'h0, 32'h0000_0000, 4'hF);
      b_far <= 8'h3C;
      tick(1);
      cap(1'b0, 1'b1);
      bus(1'b0, 4'h4, 32'h0000_0000, 4'hF);
      chk("status capture", 32'h0001_3C96, rd);
      $display("test transceiver capture done");

      // live data differs from stored so a wrong source shows at once
      a_far <= 8'h11;
      b_far <= 8'h22;
      for (int c = 0; c < 16; c++) begin
         cv = 4'(c);
         bus(1'b1, 4'h0, {28'h000_0000, cv}, 4'hF);
         tick(3);
         exp_a = cv[2] ? 8'h3C : 8'h22;
         exp_b = cv[3] ? 8'h96 : 8'h11;
         chk("a_oe", {31'h0000_0000, !cv[0] && !cv[1]}, {31'h0000_0000, a_oe});
         chk("b_oe", {31'h0000_0000, !cv[0] && cv[1]}, {31'h0000_0000, b_oe});
         if (!cv[0] && !cv[1]) chk("a_out", {24'h00_0000, exp_a}, {24'h00_0000, a_out});
         if (!cv[0] && cv[1]) chk("b_out", {24'h00_0000, exp_b}, {24'h00_0000, b_out});
      end
      bus(1'b0, 4'h4, 32'h0000_0000, 4'hF);
      chk("status after modes", 32'h0000_3C96, rd);
      $display("test mode table done");

      // port a driven with live b, so both registers see the same byte
      bus(1'b1, 4'h0, 32'h0000_0000, 4'hF);
      b_far <= 8'h5A;
      tick(3);
      cap(1'b1, 1'b1);
      bus(1'b0, 4'h4, 32'h0000_0000, 4'hF);
      chk("status dual", 32'h0001_5A5A, rd);
      $display("test dual capture done");

      sys_rst <= 1'b1;
      tick(2);
      sys_rst <= 1'b0;
      tick(1);
      bus(1'b0, 4'h0, 32'h0000_0000, 4'hF);
      chk("ctrl rereset", 32'h0000_0001, rd);
      bus(1'b0, 4'h4, 32'h0000_0000, 4'hF);
      chk("status rereset", 32'h0000_0000, rd);
      $display("test mid reset done");
      results();
   end
endmodule
`default_nettype wire
